// ===== sar_cmd_pkg.sv
// Shared constants and types for the serial command port of the SAR converter.
// Assumes one system clock that oversamples the serial link pins.
package sar_cmd_pkg;

   // ----------------------------------------------------------------
   // Bit positions, counted in serial clock falls after the start bit
   // ----------------------------------------------------------------
   localparam int CNT_W = 5;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_MODE = 5'h01;
   localparam logic [4:0] CNT_CMD_LAST = 5'h04;
   localparam logic [4:0] CNT_CLOSE = 5'h05;
   localparam logic [4:0] CNT_NULL = 5'h06;
   localparam logic [4:0] CNT_MSB_LAST = 5'h12;
   localparam logic [4:0] CNT_LSB_LAST = 5'h1d;
   localparam logic [4:0] CNT_MAX = 5'h1f;

   // ----------------------------------------------------------------
   // Result code
   // ----------------------------------------------------------------
   localparam int CODE_W = 12;
   localparam int RAW_W = 14;
   localparam logic [11:0] CODE_ZERO = 12'h000;
   localparam logic [11:0] CODE_FULL = 12'hfff;
   localparam logic signed [13:0] RAW_FULL = 14'sh0fff;

   // ----------------------------------------------------------------
   // States, mux selection and reset values
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_HUNT = 4'h2,
      ST_CMD = 4'h4,
      ST_SHIFT = 4'h8
   } state_type;

   typedef struct packed {
      logic single_ended;
      logic [2:0] pos;
      logic [2:0] neg;
   } chan_sel_type;

   localparam chan_sel_type CHAN_RST = 7'h40;
   localparam logic [3:0] CMD_RST = 4'h0;
   localparam logic SYNC_RST = 1'b0;
   localparam logic OE_N_RST = 1'b1;
   localparam logic STANDBY_RST = 1'b1;

endpackage

// ===== sar_cmd_port.sv
// Serial command and result port of a 12-bit SAR converter with 4 or 8 inputs.
// Assumes the serial clock, select and data-in pins are asynchronous and much
// slower than ref_clk_in (at least four system clocks per serial half period).
`timescale 1ns/1ps

module sar_cmd_port #(
   parameter int NUM_INPUTS = 8
) (
   // System
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   // Serial link pins
   input wire logic sclk_in,
   input wire logic select_shutdown_n_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_n_out,
   // Converter core
   input wire logic signed [sar_cmd_pkg::RAW_W-1:0] raw_code_in,
   output sar_cmd_pkg::chan_sel_type analog_inputs_sel_out,
   output logic sample_hold_out,
   output logic standby_out,
   output logic [sar_cmd_pkg::CODE_W-1:0] result_out
);

   if (NUM_INPUTS != 4 && NUM_INPUTS != 8) begin : g_bad_inputs
      $error("NUM_INPUTS must be 4 or 8");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
   logic cs_s1_ff, cs_s2_ff;
   logic din_s1_ff, din_s2_ff;

   // Data and clock share the same latency, so data stays aligned to edges
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sclk_s1_ff <= sar_cmd_pkg::SYNC_RST;
         sclk_s2_ff <= sar_cmd_pkg::SYNC_RST;
         sclk_d_ff <= sar_cmd_pkg::SYNC_RST;
         cs_s1_ff <= sar_cmd_pkg::SYNC_RST;
         cs_s2_ff <= sar_cmd_pkg::SYNC_RST;
         din_s1_ff <= sar_cmd_pkg::SYNC_RST;
         din_s2_ff <= sar_cmd_pkg::SYNC_RST;
      end else begin
         sclk_s1_ff <= sclk_in;
         sclk_s2_ff <= sclk_s1_ff;
         sclk_d_ff <= sclk_s2_ff;
         cs_s1_ff <= select_shutdown_n_in;
         cs_s2_ff <= cs_s1_ff;
         din_s1_ff <= sdi_in;
         din_s2_ff <= din_s1_ff;
      end
   end

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   sar_cmd_pkg::state_type state_ff, nxt_state;
   logic [sar_cmd_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [3:0] cmd_ff;
   logic armed_ff, sample_ff, dout_ff, oe_n_ff, standby_ff;
   logic [sar_cmd_pkg::CODE_W-1:0] result_ff;
   sar_cmd_pkg::chan_sel_type mux_ff;

   function automatic sar_cmd_pkg::chan_sel_type decode_chan(input logic mode,
                                                             input logic [2:0] sel);
      logic [2:0] s;
      sar_cmd_pkg::chan_sel_type c;
      s = (NUM_INPUTS == 8) ? sel : {1'b0, sel[1:0]};
      c.single_ended = mode;
      c.pos = s;
      c.neg = mode ? s : {s[2:1], ~s[0]};
      return c;
   endfunction

   function automatic logic [11:0] clamp_code(input logic signed [13:0] raw);
      logic [11:0] c;
      if (raw <= 14'sh0000) begin
         c = sar_cmd_pkg::CODE_ZERO;
      end else if (raw >= sar_cmd_pkg::RAW_FULL) begin
         c = sar_cmd_pkg::CODE_FULL;
      end else begin
         c = raw[11:0];
      end
      return c;
   endfunction

   wire sclk_rise = sclk_s2_ff & ~sclk_d_ff;
   wire sclk_fall = ~sclk_s2_ff & sclk_d_ff;
   wire cs_high = cs_s2_ff;
   wire din = din_s2_ff;
   wire st_hunt = (state_ff == sar_cmd_pkg::ST_HUNT);
   wire st_cmd = (state_ff == sar_cmd_pkg::ST_CMD);
   wire st_shift = (state_ff == sar_cmd_pkg::ST_SHIFT);
   wire framing = st_cmd | st_shift;
   wire start_seen = st_hunt & sclk_rise & din & ~cs_high;
   wire cmd_rise = st_cmd & sclk_rise & ~cs_high;
   wire cmd_shift_in = cmd_rise & (cnt_ff >= sar_cmd_pkg::CNT_MODE)
                       & (cnt_ff < sar_cmd_pkg::CNT_CMD_LAST);
   wire sample_open = cmd_rise & (cnt_ff == sar_cmd_pkg::CNT_CMD_LAST);
   wire sample_close = st_cmd & sclk_fall & ~cs_high & (cnt_ff == sar_cmd_pkg::CNT_CLOSE);
   wire out_fall = st_shift & sclk_fall & ~cs_high;
   wire [4:0] msb_idx = 5'(sar_cmd_pkg::CNT_MSB_LAST - cnt_ff);
   wire [4:0] lsb_idx = 5'(cnt_ff - sar_cmd_pkg::CNT_MSB_LAST);
   wire in_msb = (cnt_ff > sar_cmd_pkg::CNT_NULL) && (cnt_ff <= sar_cmd_pkg::CNT_MSB_LAST);
   wire in_lsb = (cnt_ff > sar_cmd_pkg::CNT_MSB_LAST) && (cnt_ff <= sar_cmd_pkg::CNT_LSB_LAST);
   wire nxt_bit = in_msb ? result_ff[msb_idx[3:0]] : in_lsb ? result_ff[lsb_idx[3:0]] : 1'b0;

   // count from the start bit only
   assign nxt_cnt = start_seen ? sar_cmd_pkg::CNT_ZERO :
                    (framing & sclk_fall & (cnt_ff != sar_cmd_pkg::CNT_MAX)) ?
                    5'(cnt_ff + 5'h01) : cnt_ff;

   // ----------------------------------------------------------------
   // Frame state machine
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      if (cs_high) begin
         nxt_state = sar_cmd_pkg::ST_IDLE;
      end else begin
         unique case (state_ff)
            sar_cmd_pkg::ST_IDLE: begin
               if (armed_ff) nxt_state = sar_cmd_pkg::ST_HUNT;
            end
            sar_cmd_pkg::ST_HUNT: begin
               if (start_seen) nxt_state = sar_cmd_pkg::ST_CMD;
            end
            sar_cmd_pkg::ST_CMD: begin
               if (sample_close) nxt_state = sar_cmd_pkg::ST_SHIFT;
            end
            sar_cmd_pkg::ST_SHIFT: begin
               nxt_state = sar_cmd_pkg::ST_SHIFT;
            end
            default: nxt_state = sar_cmd_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff <= sar_cmd_pkg::ST_IDLE;
         cnt_ff <= sar_cmd_pkg::CNT_ZERO;
         armed_ff <= 1'b0;
         standby_ff <= sar_cmd_pkg::STANDBY_RST;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         // arm once select has been high
         armed_ff <= armed_ff | cs_high;
         standby_ff <= cs_high;
      end
   end

   // ----------------------------------------------------------------
   // Command capture, sampling and result
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cmd_ff <= sar_cmd_pkg::CMD_RST;
         mux_ff <= sar_cmd_pkg::CHAN_RST;
         sample_ff <= 1'b0;
         result_ff <= sar_cmd_pkg::CODE_ZERO;
      end else begin
         // shift in mode, then bit2, bit1
         if (cmd_shift_in) cmd_ff <= {cmd_ff[2:0], din};
         if (sample_open) mux_ff <= decode_chan(cmd_ff[2], {cmd_ff[1:0], din});
         if (cs_high || sample_close) begin
            sample_ff <= 1'b0;
         end else if (sample_open) begin
            sample_ff <= 1'b1;
         end
         if (sample_close) result_ff <= clamp_code(raw_code_in);
      end
   end

   // ----------------------------------------------------------------
   // Serial output
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dout_ff <= 1'b0;
         oe_n_ff <= sar_cmd_pkg::OE_N_RST;
      end else if (cs_high) begin
         dout_ff <= 1'b0;
         oe_n_ff <= sar_cmd_pkg::OE_N_RST;
      end else if (out_fall) begin
         // change only on falls, drive from null bit
         dout_ff <= nxt_bit;
         if (cnt_ff == sar_cmd_pkg::CNT_NULL) oe_n_ff <= 1'b0;
      end
   end

   assign sdo_out = dout_ff;
   assign sdo_oe_n_out = oe_n_ff;
   assign analog_inputs_sel_out = mux_ff;
   assign sample_hold_out = sample_ff;
   assign standby_out = standby_ff;
   assign result_out = result_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   a_frame_needs_low: assert property (
      $rose(st_cmd) |-> $past(!cs_high) && $past(armed_ff))
      else $error("frame started without select low");
   a_select_aborts: assert property (
      cs_high |=> state_ff == sar_cmd_pkg::ST_IDLE && !sample_ff && standby_ff)
      else $error("select high did not abort");
   a_powerup_arming: assert property (
      !armed_ff |-> state_ff == sar_cmd_pkg::ST_IDLE)
      else $error("frame hunted before select seen high");
   a_zeros_ignored: assert property (
      st_hunt && sclk_rise && !din && !cs_high |=> st_hunt)
      else $error("leading zero taken as start");
   a_start_taken: assert property (
      start_seen |=> st_cmd && cnt_ff == sar_cmd_pkg::CNT_ZERO)
      else $error("start bit missed");
   a_mode_select: assert property (
      sample_open |=> mux_ff.single_ended == $past(cmd_ff[2]) && sample_ff)
      else $error("mode bit or sample open wrong");
   a_sample_window: assert property (
      sample_close |=> !sample_ff && st_shift)
      else $error("sample window did not close");
   a_null_bit: assert property (
      out_fall && cnt_ff == sar_cmd_pkg::CNT_NULL |=> !dout_ff && !oe_n_ff)
      else $error("null bit wrong");
   a_msb_first: assert property (
      out_fall && cnt_ff == 5'h07 |=> dout_ff == result_ff[11])
      else $error("MSB not first");
   a_lsb_again: assert property (
      out_fall && cnt_ff == 5'h13 |=> dout_ff == result_ff[1])
      else $error("LSB-first copy wrong");
   a_trailing_zero: assert property (
      out_fall && cnt_ff > sar_cmd_pkg::CNT_LSB_LAST |=> !dout_ff)
      else $error("trailing bit not zero");
   a_out_on_fall: assert property (
      st_shift && !sclk_fall && !cs_high |=> $stable(dout_ff))
      else $error("output changed off a fall");
   a_released_cmd: assert property (
      st_hunt || st_cmd |-> oe_n_ff)
      else $error("output driven during command");
   a_code_clamp: assert property (
      sample_close && raw_code_in < 14'sh0000 |=> result_ff == sar_cmd_pkg::CODE_ZERO)
      else $error("negative code not clamped");
   a_sample_opens: assert property (
      sample_open |=> sample_ff && cnt_ff == sar_cmd_pkg::CNT_CMD_LAST)
      else $error("sample window did not open on fourth rise");
   a_channel_bits: assert property (
      sample_open |=> mux_ff.pos[1:0] == $past({cmd_ff[0], din}))
      else $error("channel bits taken out of order");
   a_released_idle: assert property (
      !st_shift |-> oe_n_ff)
      else $error("output driven outside shift");

   c_full_frame: cover property (out_fall && cnt_ff == sar_cmd_pkg::CNT_LSB_LAST);
   c_abort_cmd: cover property (st_cmd && cs_high);
   c_leading_zero: cover property (st_hunt && sclk_rise && !din && !cs_high);
   c_diff_mode: cover property (sample_open && !cmd_ff[2]);
   c_lsb_copy: cover property (out_fall && cnt_ff == 5'h13);

endmodule

// ===== sar_host_model.sv
// Behavioural SPI master standing on the host side of the converter port.
// Assumes ref_clk_in is the bench clock; four of its cycles make half a serial clock.
`timescale 1ns/1ps

module sar_host_model (
   // System
   input wire logic ref_clk_in,
   // Converter port pins
   input wire logic sdo_in,
   input wire logic sdo_oe_n_in,
   input wire logic sample_hold_in,
   output logic sclk_out,
   output logic select_shutdown_n_out,
   output logic sdi_out
);
   localparam int HALF = 4;
   logic sdo_wire;
   logic [63:0] cap_bit;
   logic [63:0] cap_oe_n;
   logic [63:0] cap_sh;

   // Released line has no pull: show the inverse so a stale bit cannot pass
   assign sdo_wire = sdo_oe_n_in ? ~sdo_in : sdo_in;

   // Select starts low, as if the pin was held asserted at power-up
   initial begin
      sclk_out = 1'b0;
      select_shutdown_n_out = 1'b0;
      sdi_out = 1'b0;
   end

   // ----------------------------------------------------------------
   // Frame: pad zeros, start, mode, three channel bits, filler clocks
   // ----------------------------------------------------------------
   task automatic frame(input int pad, input logic [3:0] cmd, input logic dc_bit,
         input int nclk, input logic idle_high);
      logic bit_v;
      @(posedge ref_clk_in);
      sclk_out <= idle_high;
      repeat (2 * HALF) @(posedge ref_clk_in);
      select_shutdown_n_out <= 1'b0;
      repeat (2 * HALF) @(posedge ref_clk_in);
      for (int c = 1; c <= nclk; c++) begin
         if (c == pad + 1) bit_v = 1'b1;
         else if (c > pad + 1 && c <= pad + 5) bit_v = cmd[pad + 5 - c];
         else if (c == pad + 6) bit_v = dc_bit;
         else bit_v = 1'b0;
         sclk_out <= 1'b0;
         sdi_out <= bit_v;
         repeat (HALF) @(posedge ref_clk_in);
         sclk_out <= 1'b1;
         @(negedge ref_clk_in);
         cap_bit[c] = sdo_wire;
         cap_oe_n[c] = sdo_oe_n_in;
         cap_sh[c] = sample_hold_in;
         repeat (HALF) @(posedge ref_clk_in);
      end
      if (!idle_high) sclk_out <= 1'b0;
   endtask

   task automatic end_frame();
      @(posedge ref_clk_in);
      select_shutdown_n_out <= 1'b1;
      repeat (2 * HALF) @(posedge ref_clk_in);
   endtask
endmodule

// ===== sar_adc_serial_command_port_bench.sv
// Self-checking bench for the converter's serial command and result port.
// Assumes the host model drives the clock, select and data-in link pins; the bench drives reset and the raw code.
`timescale 1ns/1ps

module sar_adc_serial_command_port_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic signed [sar_cmd_pkg::RAW_W-1:0] raw = 14'sh0000;
   logic sclk, sel_n, sdi, sdo, sdo_oe_n, sample_hold, standby;
   sar_cmd_pkg::chan_sel_type chan;
   sar_cmd_pkg::chan_sel_type chan4;
   logic [sar_cmd_pkg::CODE_W-1:0] result;
   int errors = 0;
   int checked = 0;

   always #50 clk = ~clk;

   sar_cmd_port #(.NUM_INPUTS(8)) dut_u (.ref_clk_in(clk), .nrst_in(nrst),
      .sclk_in(sclk), .select_shutdown_n_in(sel_n), .sdi_in(sdi), .sdo_out(sdo),
      .sdo_oe_n_out(sdo_oe_n), .raw_code_in(raw), .analog_inputs_sel_out(chan),
      .sample_hold_out(sample_hold), .standby_out(standby), .result_out(result));
   // Four-input build shares the pins so every frame after the power-up one also exercises its decode
   sar_cmd_port #(.NUM_INPUTS(4)) dut4_u (.ref_clk_in(clk), .nrst_in(nrst),
      .sclk_in(sclk), .select_shutdown_n_in(sel_n), .sdi_in(sdi), .sdo_out(),
      .sdo_oe_n_out(), .raw_code_in(raw), .analog_inputs_sel_out(chan4),
      .sample_hold_out(), .standby_out(), .result_out());
   sar_host_model host_u (.ref_clk_in(clk), .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n),
      .sample_hold_in(sample_hold), .sclk_out(sclk), .select_shutdown_n_out(sel_n),
      .sdi_out(sdi));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   function automatic sar_cmd_pkg::chan_sel_type exp_sel(input logic [3:0] cmd, input int n);
      logic [2:0] ch;
      ch = (n == 4) ? {1'b0, cmd[1:0]} : cmd[2:0];
      exp_sel.single_ended = cmd[3];
      exp_sel.pos = ch;
      exp_sel.neg = cmd[3] ? ch : {ch[2:1], ~ch[0]};
   endfunction

   // Clock index counted from the start clock; null, MSB run, LSB run, then zeros
   function automatic logic exp_bit(input logic [11:0] code, input int c);
      if (c >= 9 && c <= 20) return code[20 - c];
      if (c >= 21 && c <= 31) return code[c - 20];
      return 1'b0;
   endfunction

   task automatic end_of_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_powerup();
      host_u.frame(0, 4'b1000, 1'b1, 35, 1'b0);
      check(host_u.cap_oe_n[35:1] === {35{1'b1}}, "answered without select toggle");
      check(host_u.cap_sh[35:1] === 35'h0, "sampled without select toggle");
      host_u.end_frame();
      $display("test powerup done");
   endtask

   task automatic test_full(input logic signed [13:0] raw_v, input logic [11:0] code,
         input int pad, input logic idle_high, input logic [3:0] cmd);
      int p;
      @(posedge clk);
      raw <= raw_v;
      host_u.frame(pad, cmd, 1'b1, pad + 35, idle_high);
      for (int c = 1 - pad; c <= 35; c++) begin
         p = pad + c;
         check(host_u.cap_oe_n[p] === (c < 8), "output enable timing");
         check(host_u.cap_sh[p] === (c == 6), "sample window");
         if (c >= 8) check(host_u.cap_bit[p] === exp_bit(code, c), "serial bit");
      end
      check(standby === 1'b0, "standby in frame");
      host_u.end_frame();
      check(standby === 1'b1 && sdo_oe_n === 1'b1, "standby after frame");
      check(result === code, "clamped result");
      $display("test full frame done");
   endtask

   task automatic test_channels();
      for (int m = 0; m < 16; m++) begin
         host_u.frame(0, m[3:0], 1'b0, 7, 1'b0);
         check(chan === exp_sel(m[3:0], 8), "eight input select");
         check(chan4 === exp_sel(m[3:0], 4), "four input select");
         host_u.end_frame();
      end
      $display("test channels done");
   endtask

   task automatic test_abort();
      host_u.frame(0, 4'b1010, 1'b0, 5, 1'b0);
      check(sample_hold === 1'b1 && sdo_oe_n === 1'b1, "sampling before abort");
      host_u.end_frame();
      check(sample_hold === 1'b0 && chan === exp_sel(4'b1010, 8), "abort in sampling");
      @(posedge clk);
      raw <= 14'sh0555;
      host_u.frame(0, 4'b1101, 1'b1, 12, 1'b0);
      check(sdo_oe_n === 1'b0, "driving before abort");
      host_u.end_frame();
      check(sdo_oe_n === 1'b1 && sdo === 1'b0, "output after abort");
      check(sample_hold === 1'b0 && standby === 1'b1, "standby after abort");
      $display("test abort done");
   endtask

   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      test_powerup();
      test_full(14'sh0abc, 12'habc, 5, 1'b0, 4'b1000);
      test_full(14'sh3ffb, 12'h000, 0, 1'b1, 4'b0001);
      test_channels();
      test_abort();
      test_full(14'sh1234, 12'hfff, 2, 1'b0, 4'b1111);
      test_full(14'sh0001, 12'h001, 0, 1'b1, 4'b0110);
      end_of_test();
   end

   // Run needs about 3100 cycles; the limit leaves a wide margin
   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test();
   end
endmodule
